/* rtl/psu_seq_defines.vh */
// Constants of the supply status sequencer.
// Assumes a 125 MHz hclk; times are kept in their own units.
`ifndef PSU_SEQ_DEFINES_VH
`define PSU_SEQ_DEFINES_VH
// =============================================================
// Clock
// =============================================================
`define CLK_KHZ 125000
// =============================================================
// Timing figures (ms)
// =============================================================
`define T_GOOD_ON1_MS 2000
`define T_GOOD_ON2_MS 100
`define T_GOOD_OFF_MS 5
`define T_MAIN_DEL_MIN_MS 10
`define T_MAIN_DEL_MAX_MS 500
`define T_SB_HOLD_MS 15
`define T_MAIN_HOLD_MS 7
`define T_OFF_MIN_MS 1000
`define T_OFF_MAX_MS 2000
`define T_DIP_SHORT_MS 10
`define T_DIP_LONG_MS 100
`define T_BLINK_HALF_MS 500
// =============================================================
// Timing choices inside the windows (ms)
// =============================================================
`define T_GOOD_ON1_USE_MS 1000
`define T_GOOD_ON2_USE_MS 50
`define T_GOOD_OFF_USE_MS 2
`define T_MAIN_DEL_USE_MS 100
`define T_OFF_USE_MS 1500
// =============================================================
// Millisecond tick
// =============================================================
// Clock in kHz is the cycle count of one millisecond
`define MS_CYCLES `CLK_KHZ
// =============================================================
// Register map (AHB-Lite byte offsets)
// =============================================================
`define REG_CTRL 12'h000
`define REG_STATUS 12'h004
`define REG_LED 12'h008
// CTRL field positions
`define CTRL_OV 0
`define CTRL_OC 1
`define CTRL_OT 2
`define CTRL_FAN 3
`define CTRL_WARN_TEMP 4
`define CTRL_WARN_POWER 5
`define CTRL_WARN_FAN 6
`define CTRL_RESET 32'h0000_0000
// STATUS field positions
`define ST_MAINS 0
`define ST_SB 1
`define ST_MAIN 2
`define ST_GOOD 3
`define ST_FAULT 4
`define ST_DIP_SHORT 5
`define ST_DIP_LONG 6
`define ST_KILL 7
`endif

/* rtl/ms_tick.v */
// Millisecond enable pulse and slow blink phase.
// Assumes one clock, hclk, and async active-low reset.
`timescale 1ns/1ps
`include "psu_seq_defines.vh"
module ms_tick #(
    parameter integer MS_CYCLES = `MS_CYCLES,
    parameter integer BLINK_MS = `T_BLINK_HALF_MS
) (
    input wire hclk,
    input wire hresetn,
    output reg ms_pulse,
    output reg blink
);
    reg [16:0] div;
    reg [9:0] bcnt;
    // =========================================================
    // Divider
    // =========================================================
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div <= 17'h00000;
            ms_pulse <= 1'b0;
            bcnt <= 10'h000;
            blink <= 1'b0;
        end else begin
            ms_pulse <= 1'b0;
            if (div == MS_CYCLES[16:0] - 17'h00001) begin
                div <= 17'h00000;
                ms_pulse <= 1'b1;
                if (bcnt == BLINK_MS[9:0] - 10'h001) begin
                    bcnt <= 10'h000;
                    blink <= ~blink;
                end else begin
                    bcnt <= bcnt + 10'h001;
                end
            end else begin
                div <= div + 17'h00001;
            end
        end
    end
endmodule

/* rtl/psu_status_sequencer.v */
// Supervisory sequencer: indicators, kill, presence, turn-on, power-good.
// Assumes synchronous inputs on hclk and an AHB-Lite master alone.
`timescale 1ns/1ps
`include "psu_seq_defines.vh"
module psu_status_sequencer #(
    parameter integer ON1_MS = `T_GOOD_ON1_USE_MS,
    parameter integer OFF_MS = `T_OFF_USE_MS,
    parameter integer MS_CYCLES = `MS_CYCLES,
    parameter integer BLINK_MS = `T_BLINK_HALF_MS
) (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [11:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    input wire mains_ok,
    input wire output_enable_n,
    input wire insertion_kill,
    input wire seated,
    output reg standby_en,
    output reg main_output,
    output reg input_power_good,
    output reg present_n,
    output reg led_green,
    output reg led_amber
);
    localparam [2:0] S_OFF = 3'h0;
    localparam [2:0] S_SB_WAIT = 3'h1;
    localparam [2:0] S_SB_ON = 3'h2;
    localparam [2:0] S_MAIN_ON = 3'h3;
    localparam [2:0] S_HOLD = 3'h4;
    localparam [2:0] S_RESTART = 3'h5;
    // =========================================================
    // Timing constants, cut to the 12-bit millisecond timers
    // =========================================================
    localparam integer ON2_MS = `T_GOOD_ON2_USE_MS;
    localparam integer OFFDEL_MS = `T_GOOD_OFF_USE_MS;
    localparam integer MDEL_MS = `T_MAIN_DEL_USE_MS;
    localparam integer SBHOLD_MS = `T_SB_HOLD_MS;
    localparam integer MHOLD_MS = `T_MAIN_HOLD_MS;
    localparam integer DSHORT_MS = `T_DIP_SHORT_MS;
    localparam integer DLONG_MS = `T_DIP_LONG_MS;
    localparam [11:0] ON1 = ON1_MS[11:0];
    localparam [11:0] ON2 = ON2_MS[11:0];
    localparam [11:0] OFFDEL = OFFDEL_MS[11:0];
    localparam [11:0] MDEL = MDEL_MS[11:0];
    localparam [11:0] SBHOLD = SBHOLD_MS[11:0];
    localparam [11:0] MHOLD = MHOLD_MS[11:0];
    localparam [11:0] OFFT = OFF_MS[11:0];
    localparam [11:0] DSHORT = DSHORT_MS[11:0];
    localparam [11:0] DLONG = DLONG_MS[11:0];

    wire ms_pulse;
    wire blink;
    reg [2:0] state;
    reg [11:0] tmr;
    reg [11:0] good_tmr;
    reg [11:0] loss_tmr;
    reg [11:0] dip_len;
    reg main_off_ok;
    reg [11:0] main_off_tmr;
    reg was_on;
    reg dip_recover;
    reg dip_short;
    reg dip_long;
    reg [31:0] ctrl;
    reg fault_latch;
    reg en_prev;
    reg ph_valid;
    reg ph_write;
    reg [11:0] ph_addr;
    reg next_green;
    reg next_amber;
    wire fail_in;
    wire warn_in;
    wire mains_q;
    wire sb_hold_done;
    wire main_hold_done;

    // =========================================================
    // Slow timebase
    // =========================================================
    ms_tick #(
        .MS_CYCLES(MS_CYCLES),
        .BLINK_MS(BLINK_MS)
    ) u_tick (
        .hclk(hclk),
        .hresetn(hresetn),
        .ms_pulse(ms_pulse),
        .blink(blink)
    );

    // =========================================================
    // AHB-Lite slave, zero wait states
    // =========================================================
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ph_valid <= 1'b0;
            ph_write <= 1'b0;
            ph_addr <= 12'h000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else if (hready) begin
            ph_valid <= hsel & htrans[1];
            ph_write <= hwrite;
            ph_addr <= haddr;
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl <= `CTRL_RESET;
        end else if (ph_valid && ph_write && ph_addr == `REG_CTRL) begin
            ctrl <= {25'h0000000, hwdata[6:0]};
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (hready && hsel && htrans[1] && !hwrite) begin
            case (haddr)
                `REG_CTRL: hrdata <= ctrl;
                `REG_STATUS: hrdata <= {24'h000000, insertion_kill,
                    dip_long, dip_short, fault_latch, input_power_good,
                    main_output, standby_en, mains_q};
                `REG_LED: hrdata <= {30'h00000000, led_amber, led_green};
                default: hrdata <= 32'h0000_0000;
            endcase
        end
    end

    // =========================================================
    // Fault latch, cleared by toggling the enable input
    // =========================================================
    assign fail_in = ctrl[`CTRL_OV] | ctrl[`CTRL_OC] | ctrl[`CTRL_OT] |
        ctrl[`CTRL_FAN];
    assign warn_in = ctrl[`CTRL_WARN_TEMP] | ctrl[`CTRL_WARN_POWER] |
        ctrl[`CTRL_WARN_FAN];
    assign mains_q = mains_ok;

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fault_latch <= 1'b0;
            en_prev <= 1'b1;
        end else begin
            en_prev <= output_enable_n;
            if (fail_in)
                fault_latch <= 1'b1;
            else if (output_enable_n != en_prev || !mains_q)
                fault_latch <= 1'b0;
        end
    end

    // =========================================================
    // Mains loss and dip classification
    // =========================================================
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dip_len <= 12'h000;
            dip_short <= 1'b0;
            dip_long <= 1'b0;
            dip_recover <= 1'b0;
        end else if (!mains_q) begin
            if (ms_pulse && dip_len != 12'hFFF)
                dip_len <= dip_len + 12'h001;
        end else if (dip_len != 12'h000) begin
            dip_len <= 12'h000;
            if (was_on) begin
                dip_short <= dip_len < DSHORT;
                dip_long <= dip_len >= DSHORT && dip_len <= DLONG;
                dip_recover <= dip_len <= DLONG;
            end
        end else if (!was_on) begin
            dip_recover <= 1'b0;
        end
    end

    // =========================================================
    // Power-good output
    // =========================================================
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            input_power_good <= 1'b0;
            good_tmr <= 12'h000;
            loss_tmr <= 12'h000;
            was_on <= 1'b0;
        end else if (!mains_q) begin
            good_tmr <= 12'h000;
            if (ms_pulse && loss_tmr != 12'hFFF)
                loss_tmr <= loss_tmr + 12'h001;
            if (loss_tmr >= OFFDEL)
                input_power_good <= 1'b0;
            if (loss_tmr >= DLONG)
                was_on <= 1'b0;
        end else begin
            loss_tmr <= 12'h000;
            if (ms_pulse && !input_power_good)
                good_tmr <= good_tmr + 12'h001;
            if (!input_power_good &&
                good_tmr >= (dip_recover ? ON2 : ON1)) begin
                input_power_good <= 1'b1;
                was_on <= 1'b1;
            end
        end
    end

    // =========================================================
    // Output sequencer
    // =========================================================
    // One tick past each hold figure: the first tick can come at once
    assign sb_hold_done = tmr > SBHOLD;
    assign main_hold_done = state == S_HOLD && tmr > MHOLD;

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= S_OFF;
            tmr <= 12'h000;
            standby_en <= 1'b0;
        end else begin
            // Timer sticks at full scale so a long wait cannot wrap
            if (ms_pulse && tmr != 12'hFFF)
                tmr <= tmr + 12'h001;
            case (state)
                S_OFF: begin
                    tmr <= 12'h000;
                    if (mains_q) begin
                        standby_en <= 1'b1;
                        state <= S_SB_ON;
                    end
                end
                S_SB_ON: begin
                    if (!input_power_good && !mains_q) begin
                        tmr <= 12'h000;
                        state <= S_HOLD;
                    end
                end
                S_HOLD: begin
                    // Mains back inside the hold: ride through the dip
                    if (mains_q) begin
                        state <= S_SB_ON;
                    end else if (sb_hold_done) begin
                        standby_en <= 1'b0;
                        tmr <= 12'h000;
                        state <= S_RESTART;
                    end
                end
                S_RESTART: begin
                    if (tmr >= OFFT)
                        state <= S_OFF;
                end
                default: state <= S_OFF;
            endcase
        end
    end

    // Main output: delay after standby, kill, enable, off time
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            main_output <= 1'b0;
            main_off_tmr <= 12'h000;
            main_off_ok <= 1'b1;
        end else begin
            if (ms_pulse && main_off_tmr != 12'hFFF && !main_output)
                main_off_tmr <= main_off_tmr + 12'h001;
            if (main_off_tmr >= OFFT)
                main_off_ok <= 1'b1;
            if (insertion_kill || output_enable_n || fault_latch ||
                !standby_en ||
                main_hold_done) begin
                if (main_output) begin
                    main_off_tmr <= 12'h000;
                    main_off_ok <= 1'b0;
                end
                main_output <= 1'b0;
            end else if (state == S_SB_ON && tmr >= MDEL &&
                main_off_ok) begin
                main_output <= 1'b1;
            end
        end
    end

    // =========================================================
    // Indicators and presence
    // =========================================================
    always @* begin
        next_green = 1'b0;
        next_amber = 1'b0;
        // No mains: dark even while the outputs hold up
        if (!mains_q) begin
            next_green = 1'b0;
        end else if (fault_latch) begin
            next_amber = 1'b1;
        end else if (warn_in) begin
            next_amber = blink;
        end else if (standby_en && !main_output) begin
            next_green = blink;
        end else if (main_output && input_power_good) begin
            next_green = 1'b1;
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            led_green <= 1'b0;
            led_amber <= 1'b0;
            present_n <= 1'b1;
        end else begin
            led_green <= next_green;
            led_amber <= next_amber;
            present_n <= ~seated;
        end
    end
endmodule

/* sim/psu_seq_assertions.sv */
// Checker on the sequencer's outputs.
// Assumes a bind onto psu_status_sequencer.
`timescale 1ns/1ps
module psu_seq_assertions #(
    parameter integer MS_CYCLES = 125000,
    parameter integer OFF_MS = 1500
) (
    input wire hclk,
    input wire hresetn,
    input wire mains_ok,
    input wire output_enable_n,
    input wire insertion_kill,
    input wire seated,
    input wire standby_en,
    input wire main_output,
    input wire input_power_good,
    input wire present_n,
    input wire led_green,
    input wire led_amber
);
    localparam integer MS = MS_CYCLES;
    localparam integer BIG = 32'h4000_0000;
    integer sb_up, mains_dn, good_dn, main_dn, sb_dn;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // ============================================================
    // Cycle counters
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sb_up <= 0;
            mains_dn <= 0;
            good_dn <= BIG;
            main_dn <= BIG;
            sb_dn <= BIG;
        end else begin
            sb_up <= standby_en ? sb_up + 1 : 0;
            mains_dn <= mains_ok ? 0 : mains_dn + 1;
            good_dn <= input_power_good ? 0 : good_dn + 1;
            main_dn <= main_output ? 0 : main_dn + 1;
            sb_dn <= standby_en ? 0 : sb_dn + 1;
        end
    end
    sequence kill_rise;
        $rose(insertion_kill) && standby_en;
    endsequence
    // ============================================================
    // Properties
    AST_DARK: assert property (
        !mains_ok [*3] |-> !led_green && !led_amber)
        else $error("indicator lit without mains");
    AST_KILL: assert property (insertion_kill |=> !main_output)
        else $error("main on under kill");
    AST_SB_KILL: assert property (kill_rise |=> standby_en)
        else $error("standby dropped by kill");
    AST_PRESENT: assert property (
        $past(hresetn) |-> present_n == !$past(seated))
        else $error("presence wrong");
    AST_MAIN_DELAY: assert property (
        $rose(main_output) |-> sb_up >= 10 * MS)
        else $error("main too soon after standby");
    AST_GOOD_DROP: assert property (
        input_power_good && !mains_ok |-> mains_dn < 5 * MS)
        else $error("power good held too long");
    AST_SB_HOLD: assert property (
        $fell(standby_en) |-> good_dn >= 15 * MS)
        else $error("standby hold too short");
    AST_MAIN_OFF: assert property (
        $rose(main_output) |-> main_dn >= (OFF_MS - 1) * MS)
        else $error("main off time too short");
    AST_SB_OFF: assert property (
        $rose(standby_en) |-> sb_dn >= (OFF_MS - 1) * MS)
        else $error("standby restarted too soon");
    AST_ENABLE: assert property (output_enable_n |=> !main_output)
        else $error("main on while disabled");
endmodule
bind psu_status_sequencer psu_seq_assertions #(
    .MS_CYCLES(MS_CYCLES),
    .OFF_MS(OFF_MS)
) chk (.hclk(hclk), .hresetn(hresetn), .mains_ok(mains_ok),
    .output_enable_n(output_enable_n), .insertion_kill(insertion_kill),
    .seated(seated), .standby_en(standby_en), .main_output(main_output),
    .input_power_good(input_power_good), .present_n(present_n),
    .led_green(led_green), .led_amber(led_amber));

/* sim/pdu_model.sv */
// Distribution controller facing the supply.
// Assumes the bench drives on_req and pull_out at clock edges.
`timescale 1ns/1ps
module pdu_model (
    input wire on_req,
    input wire pull_out,
    output wire output_enable_n,
    output wire insertion_kill,
    output wire seated
);
    // Open drain: released enable reads the pull-up level
    assign output_enable_n = on_req ? 1'h0 : 1'h1;
    // Kill pin grounded while seated
    assign insertion_kill = pull_out;
    assign seated = !pull_out;
endmodule

/* sim/psu_status_sequencer_bench.sv */
// Self-checking bench for the supply status sequencer.
// Assumes the design under rtl/, the checker and pdu_model.
`timescale 1ns/1ps
module psu_status_sequencer_bench;
    localparam integer MS = 10;
    localparam integer OFF = 30;
    logic hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0;
    logic [11:0] haddr = 12'h000;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0, rd;
    logic mains_ok = 1'h0, on_req = 1'h1, pull_out = 1'h0;
    wire [31:0] hrdata;
    wire hreadyout, hresp, output_enable_n, insertion_kill, seated;
    wire standby_en, main_output, input_power_good, present_n;
    wire led_green, led_amber;
    wire [4:0] outs;
    integer n_mismatch = 0, checks_done = 0, c, c0, n, b;
    assign outs = {led_amber, main_output, input_power_good, standby_en,
        led_green};
    always #4 hclk = ~hclk;
    pdu_model pdu (.on_req(on_req), .pull_out(pull_out),
        .output_enable_n(output_enable_n), .insertion_kill(insertion_kill),
        .seated(seated));
    psu_status_sequencer #(.ON1_MS(20), .OFF_MS(OFF), .MS_CYCLES(MS),
        .BLINK_MS(4)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .mains_ok(mains_ok),
        .output_enable_n(output_enable_n), .insertion_kill(insertion_kill),
        .seated(seated), .standby_en(standby_en), .main_output(main_output),
        .input_power_good(input_power_good), .present_n(present_n),
        .led_green(led_green), .led_amber(led_amber));
    // ============================================================
    // Helpers
    task chk(input string s, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", s, e, g);
        end
    endtask
    task tick(input integer k);
        repeat (k) @(posedge hclk);
        #1;
    endtask
    task wait_for(input integer i, input integer lim, output integer k);
        k = 0;
        while (outs[i] !== 1'h1 && k < lim) begin
            tick(1);
            k++;
        end
        chk("wait", 1'h1, outs[i]);
    endtask
    task toggles(input integer i, input integer cyc, output integer k);
        logic p;
        k = 0;
        p = outs[i];
        repeat (cyc) begin
            tick(1);
            if (outs[i] !== p) k++;
            p = outs[i];
        end
    endtask
    task blink_ok(input integer i);
        toggles(i, 200, n);
        chk("blinks", 1'h1, n >= 4 && n <= 5);
    endtask
    task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'h1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge hclk); while (hreadyout !== 1'h1);
        htrans <= 2'h0;
        hsel <= 1'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'h1);
        rd = hrdata;
        #1;
    endtask
    task give_verdict;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // ============================================================
    // Scenarios
    task t_start;
        tick(1);
        chk("leds", 2'h0, {led_green, led_amber});
        chk("present_n", 1'h0, present_n);
        bus(1'h0, 12'h000, 32'h0);
        chk("ctrl", 32'h0, rd);
        bus(1'h0, 12'hFFC, 32'h0);
        chk("unmapped", 32'h0, rd);
        @(posedge hclk) mains_ok <= 1'h1;
        wait_for(1, 3, c);
        wait_for(2, 2000 * MS, c0);
        blink_ok(0);
        chk("amber", 1'h0, led_amber);
        wait_for(3, 500 * MS, c);
        c = c + c0 + 200;
        chk("delay", 1'h1, c >= 10 * MS && c <= 500 * MS);
        tick(2);
        chk("on leds", 2'h2, {led_green, led_amber});
        toggles(0, 100, n);
        chk("steady", 0, n);
        $display("start done");
    endtask
    task t_faults;
        for (b = 0; b < 4; b++) begin
            bus(1'h1, 12'h000, 32'h70 | (32'h1 << b));
            tick(2);
            chk("fault leds", 2'h1, {led_green, led_amber});
            chk("fault main", 1'h0, main_output);
            toggles(4, 100, n);
            chk("amber steady", 0, n);
            bus(1'h1, 12'h000, 32'h0);
            tick(2);
            chk("latched", 1'h1, led_amber);
            @(posedge hclk) on_req <= 1'h0;
            tick(2);
            chk("disabled", 1'h0, main_output);
            @(posedge hclk) on_req <= 1'h1;
            wait_for(3, 200 * MS, c);
            tick(2);
            chk("cleared", 2'h2, {led_green, led_amber});
        end
        $display("faults done");
    endtask
    task t_warn;
        for (b = 4; b < 7; b++) begin
            bus(1'h1, 12'h000, 32'h1 << b);
            tick(2);
            chk("warn green", 1'h0, led_green);
            blink_ok(4);
            chk("warn main", 1'h1, main_output);
        end
        bus(1'h1, 12'h000, 32'h0);
        $display("warn done");
    endtask
    task t_kill;
        @(posedge hclk) pull_out <= 1'h1;
        tick(1);
        chk("kill main", 1'h0, main_output);
        chk("kill standby", 1'h1, standby_en);
        tick(1);
        chk("present_n", 1'h1, present_n);
        @(posedge hclk) pull_out <= 1'h0;
        wait_for(3, 200 * MS, c);
        $display("kill done");
    endtask
    task dip(input integer len, input logic [1:0] kind);
        @(posedge hclk) mains_ok <= 1'h0;
        tick(len * MS - 1);
        chk("dip good", 1'h0, input_power_good);
        @(posedge hclk) mains_ok <= 1'h1;
        wait_for(2, 100 * MS, c);
        bus(1'h0, 12'h004, 32'h0);
        chk("dip kind", kind, rd[6:5]);
        wait_for(3, 200 * MS, c);
        $display("dip done");
    endtask
    initial begin
        repeat (2) @(posedge hclk);
        hresetn <= 1'h1;
        t_start;
        t_faults;
        t_warn;
        t_kill;
        dip(5, 2'h1);
        dip(50, 2'h2);
        @(posedge hclk) mains_ok <= 1'h0;
        tick(40 * MS);
        chk("dark", 2'h0, {led_green, led_amber});
        chk("standby off", 1'h0, standby_en);
        give_verdict;
    end
    initial begin
        #(60000 * 8);
        n_mismatch++;
        give_verdict;
    end
endmodule
